// File: acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// ----------------------------------------------------------------------
// Clock and register map
// ----------------------------------------------------------------------
`define ACS_CLK_NS      100
`define ACS_OFS_SETUP   6'h01
`define ACS_OFS_CAL     6'h02
`define ACS_OFS_DROP    6'h04
`define ACS_SETUP_RST   16'hFB68
`define ACS_CAL_RST     15'h1000
`define ACS_DROP_RST    16'h0000
// ----------------------------------------------------------------------
// Converter setup field positions
// ----------------------------------------------------------------------
`define ACS_MODE_HI     15
`define ACS_MODE_LO     12
`define ACS_BCT_HI      11
`define ACS_BCT_LO      9
`define ACS_DCT_HI      8
`define ACS_DCT_LO      6
`define ACS_TCT_HI      5
`define ACS_TCT_LO      3
`define ACS_AVG_HI      2
`define ACS_AVG_LO      0
`define ACS_CAL_HI      14
// ----------------------------------------------------------------------
// Conversion times in microseconds, and derived cycle counts
// ----------------------------------------------------------------------
`define ACS_CT0_US      50
`define ACS_CT1_US      84
`define ACS_CT2_US      150
`define ACS_CT3_US      280
`define ACS_CT4_US      540
`define ACS_CT5_US      1052
`define ACS_CT6_US      2074
`define ACS_CT7_US      4120
`define ACS_CT_CYC(us)  ((us) * 1000 / `ACS_CLK_NS)
`endif

// File: acs_pkg.sv
package acs_pkg;
  typedef enum logic {ACS_IDLE, ACS_RUN} acs_phase_t;
  typedef enum logic [1:0] {ACS_CH_BUS, ACS_CH_DROP, ACS_CH_TEMP}
    acs_chan_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        running;
    logic        done;
  } acs_timer_st_t;

  typedef struct packed {
    logic [15:0]        setup;
    logic [14:0]        cal;
    logic [15:0]        drop;
    logic signed [25:0] acc;
    logic [10:0]        avgCnt;
    acs_chan_t          chan;
    acs_phase_t         phase;
    logic               waiting;
    logic               start;
    logic               kill;
    logic               ready;
    logic               spanNarrow;
    logic [15:0]        rdData;
  } acs_state_t;
endpackage : acs_pkg

// File: acs_conv_if.sv
interface acs_conv_if;
  logic       start;
  logic       kill;
  logic [2:0] code;
  logic       done;
  modport seq   (output start, output kill, output code, input done);
  modport timer (input start, input kill, input code, output done);
endinterface : acs_conv_if

// File: acs_conv_timer.sv
`include "acs_defs.svh"
module acs_conv_timer
  import acs_pkg::*;
#(
  parameter int unsigned CT5_CYC = `ACS_CT_CYC(`ACS_CT5_US),
  parameter int unsigned CT6_CYC = `ACS_CT_CYC(`ACS_CT6_US),
  parameter int unsigned CT7_CYC = `ACS_CT_CYC(`ACS_CT7_US)
)(
  input wire logic clk,
  input wire logic reset,
  acs_conv_if.timer cv
);
  acs_timer_st_t st_r;
  acs_timer_st_t st_nxt;

  // --------------------------------------------------------------------
  // Eight-step conversion time table
  // --------------------------------------------------------------------
  function automatic logic [15:0] ctCycles(input logic [2:0] code);
    unique case (code)
      3'h0: ctCycles = 16'(`ACS_CT_CYC(`ACS_CT0_US));
      3'h1: ctCycles = 16'(`ACS_CT_CYC(`ACS_CT1_US));
      3'h2: ctCycles = 16'(`ACS_CT_CYC(`ACS_CT2_US));
      3'h3: ctCycles = 16'(`ACS_CT_CYC(`ACS_CT3_US));
      3'h4: ctCycles = 16'(`ACS_CT_CYC(`ACS_CT4_US));
      3'h5: ctCycles = 16'(CT5_CYC);
      3'h6: ctCycles = 16'(CT6_CYC);
      3'h7: ctCycles = 16'(CT7_CYC);
    endcase
  endfunction : ctCycles

  // --------------------------------------------------------------------
  // Countdown
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (cv.kill) begin
      st_nxt.running = 1'b0;
      st_nxt.cnt     = 16'h0000;
    end else if (cv.start) begin
      st_nxt.running = 1'b1;
      st_nxt.cnt     = ctCycles(cv.code) - 16'h0001;
    end else if (st_r.running) begin
      if (st_r.cnt == 16'h0000) begin
        st_nxt.running = 1'b0;
        st_nxt.done    = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cv.done = st_r.done;
endmodule : acs_conv_timer

// File: acs_top.sv
// How it works
// [R1] Mode field bits 15-12, reset F; 0/8 shut down
// [R2] Codes 1-7: one triggered pass, mask bus/drop/temp
// [R3] Codes 9-F: continuous conversion of masked channels
// [R4] Bits 11-9 set bus conversion time
// [R5] Bits 8-6 set drop conversion time
// [R6] Bits 5-3 set temperature conversion time
// [R7] Bits 2-0 pick 1..1024 samples, all channels; only the drop result is averaged here
// [R8] Averaged result written only after full run
// [R9] Constant register: 15 writable bits, reset 1000h
// [R10] Constant drives current math and its resolution
// [R11] Drop result: read-only signed 16-bit word
// [R12] Span bit picks wide or narrow drop range
// [R13] Single shot stops, holds, rearms on write
`include "acs_defs.svh"
module acs_top
  import acs_pkg::*;
#(
  parameter int unsigned CT5_CYC = `ACS_CT_CYC(`ACS_CT5_US),
  parameter int unsigned CT6_CYC = `ACS_CT_CYC(`ACS_CT6_US),
  parameter int unsigned CT7_CYC = `ACS_CT_CYC(`ACS_CT7_US)
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic [15:0] dropSample,
  input  wire logic        inputSpanSelect,
  output logic             spanNarrow,
  output logic      [14:0] senseConstant,
  output logic             convActive,
  output logic      [1:0]  convChannel,
  output logic             convStart,
  output logic             resultReady
);
  acs_state_t st_r;
  acs_state_t st_nxt;
  acs_conv_if cv ();

  acs_conv_timer #(
    .CT5_CYC (CT5_CYC),
    .CT6_CYC (CT6_CYC),
    .CT7_CYC (CT7_CYC)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .cv    (cv)
  );

  // --------------------------------------------------------------------
  // Field views
  // --------------------------------------------------------------------
  logic [3:0]  mode;
  logic [2:0]  chanMask;
  logic        continuous;
  logic [3:0]  avgShift;
  logic [10:0] avgLast;
  logic [2:0]  ctCode;

  assign mode       = st_r.setup[`ACS_MODE_HI:`ACS_MODE_LO];
  assign chanMask   = mode[2:0];                          // see [R2]
  assign continuous = mode[3];                            // see [R3]

  // Sample count is a power of two, so the mean is a plain shift
  always_comb begin
    unique case (st_r.setup[`ACS_AVG_HI:`ACS_AVG_LO])     // see [R7]
      3'h0: avgShift = 4'h0;
      3'h1: avgShift = 4'h2;
      3'h2: avgShift = 4'h4;
      3'h3: avgShift = 4'h6;
      3'h4: avgShift = 4'h7;
      3'h5: avgShift = 4'h8;
      3'h6: avgShift = 4'h9;
      3'h7: avgShift = 4'hA;
    endcase
  end
  assign avgLast = (11'h001 << avgShift) - 11'h001;

  always_comb begin
    unique case (st_r.chan)
      ACS_CH_BUS:  ctCode = st_r.setup[`ACS_BCT_HI:`ACS_BCT_LO]; // see [R4]
      ACS_CH_DROP: ctCode = st_r.setup[`ACS_DCT_HI:`ACS_DCT_LO]; // see [R5]
      ACS_CH_TEMP: ctCode = st_r.setup[`ACS_TCT_HI:`ACS_TCT_LO]; // see [R6]
      default:     ctCode = 3'h0;
    endcase
  end

  assign cv.start = st_r.start;
  assign cv.kill  = st_r.kill;
  assign cv.code  = ctCode;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic        advance;
  logic        chanOn;
  logic [15:0] mean;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.start      = 1'b0;
    st_nxt.kill       = 1'b0;
    st_nxt.ready      = 1'b0;
    st_nxt.spanNarrow = inputSpanSelect;                  // see [R12]
    advance           = 1'b0;
    chanOn            = 1'b0;
    mean              = 16'(st_r.acc >>> avgShift);

    // Sequencer: bus, drop, temperature in turn, skipping masked ones
    if (st_r.phase == ACS_RUN) begin
      unique case (st_r.chan)
        ACS_CH_BUS:  chanOn = chanMask[0];
        ACS_CH_DROP: chanOn = chanMask[1];
        ACS_CH_TEMP: chanOn = chanMask[2];
        default:     chanOn = 1'b0;
      endcase
      if (!st_r.waiting) begin
        if (chanOn) begin
          st_nxt.start   = 1'b1;
          st_nxt.waiting = 1'b1;
        end else begin
          advance = 1'b1;
        end
      end else if (cv.done) begin
        st_nxt.waiting = 1'b0;
        advance        = 1'b1;
        if (st_r.chan == ACS_CH_DROP) begin
          st_nxt.acc = st_r.acc + 26'(signed'(dropSample));
        end
      end
    end

    if (advance) begin
      if (st_r.chan == ACS_CH_TEMP) begin
        st_nxt.chan = ACS_CH_BUS;
        if (st_r.avgCnt == avgLast) begin
          // Results move only at the end of the whole run
          if (chanMask[1]) begin
            st_nxt.drop = mean;                           // see [R8]
          end
          st_nxt.ready  = 1'b1;
          st_nxt.avgCnt = 11'h000;
          st_nxt.acc    = '0;
          if (!continuous) begin
            st_nxt.phase = ACS_IDLE;                      // see [R13]
          end
        end else begin
          st_nxt.avgCnt = st_r.avgCnt + 11'h001;
        end
      end else begin
        st_nxt.chan = acs_chan_t'(st_r.chan + 2'h1);
      end
    end

    // Register writes; a setup write restarts the sequence
    if (regWr) begin
      unique case (regAddr)
        `ACS_OFS_SETUP: begin
          st_nxt.setup   = regWrData;
          st_nxt.kill    = 1'b1;
          st_nxt.start   = 1'b0;
          st_nxt.waiting = 1'b0;
          st_nxt.chan    = ACS_CH_BUS;
          st_nxt.avgCnt  = 11'h000;
          st_nxt.acc     = '0;
          // Zero mask means shutdown: codes 0h and 8h
          st_nxt.phase = (regWrData[`ACS_MODE_LO +: 3] != 3'h0)
                         ? ACS_RUN : ACS_IDLE;            // see [R1]
        end
        `ACS_OFS_CAL: begin
          st_nxt.cal = regWrData[`ACS_CAL_HI:0];          // see [R9]
        end
        default: begin
        end
      endcase
    end

    // Read data registered one cycle after the strobe
    if (regRd) begin
      unique case (regAddr)
        `ACS_OFS_SETUP: st_nxt.rdData = st_r.setup;
        `ACS_OFS_CAL:   st_nxt.rdData = {1'b0, st_r.cal};
        `ACS_OFS_DROP:  st_nxt.rdData = st_r.drop;        // see [R11]
        default:        st_nxt.rdData = 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r            <= '0;
      st_r.setup      <= `ACS_SETUP_RST;
      st_r.cal        <= `ACS_CAL_RST;
      st_r.drop       <= `ACS_DROP_RST;
      // Reset mode is continuous, so conversion starts at once
      st_r.phase      <= ACS_RUN;
      st_r.chan       <= ACS_CH_BUS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign regRdData     = st_r.rdData;
  assign spanNarrow    = st_r.spanNarrow;
  assign senseConstant = st_r.cal;                        // see [R10]
  assign convActive    = st_r.waiting;
  assign convChannel   = st_r.chan;
  assign convStart     = st_r.start;
  assign resultReady   = st_r.ready;
endmodule : acs_top

// File: acs_check_monitor.sv
`include "acs_defs.svh"
module acs_check_monitor
  import acs_pkg::*;
#(
  parameter int unsigned CT5_CYC = 20,
  parameter int unsigned CT6_CYC = 30,
  parameter int unsigned CT7_CYC = 40
)(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [5:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        inputSpanSelect,
  input wire logic        spanNarrow,
  input wire logic        convActive,
  input wire logic [1:0]  convChannel,
  input wire logic        convStart,
  input wire logic        resultReady
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CT_TAB [8] = '{16'h01F4, 16'h0348, 16'h05DC,
    16'h0AF0, 16'h1518, 16'(CT5_CYC), 16'(CT6_CYC), 16'(CT7_CYC)};
  logic [15:0] setupSh_r;
  logic [14:0] calSh_r;
  logic [15:0] actCnt_r;
  logic [2:0]  ctCode_r;
  logic        killed_r;
  logic [10:0] dropCnt_r;
  logic [10:0] rounds;
  logic        setupWr;
  logic        dropStart;
  assign setupWr   = regWr && regAddr == `ACS_OFS_SETUP;
  assign dropStart = convStart && convChannel == 2'h1;
  assign rounds = (setupSh_r[2:0] < 3'h4)
                  ? 11'h001 << (2 * setupSh_r[2:0])
                  : 11'h001 << (setupSh_r[2:0] + 4'h3);
  // A killed conversion ends early, so its length is not judged
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setupSh_r <= `ACS_SETUP_RST;
      calSh_r   <= `ACS_CAL_RST;
      actCnt_r  <= 16'h0000;
      ctCode_r  <= 3'h5;
      killed_r  <= 1'b0;
      dropCnt_r <= 11'h000;
    end else begin
      if (setupWr) setupSh_r <= regWrData;
      if (regWr && regAddr == `ACS_OFS_CAL) calSh_r <= regWrData[14:0];
      actCnt_r <= convStart ? 16'h0000 : actCnt_r + 16'(convActive);
      if (convStart) ctCode_r <= setupSh_r[9 - 3 * convChannel +: 3];
      killed_r <= setupWr | (killed_r & ~convStart);
      if (setupWr) dropCnt_r <= 11'h000;
      else if (resultReady) dropCnt_r <= 11'(dropStart);
      else dropCnt_r <= dropCnt_r + 11'(dropStart);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_conv_len;
    $fell(convActive) && !killed_r
      |-> actCnt_r == CT_TAB[ctCode_r] + 16'h0001;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length off");
  property p_avg_run;
    resultReady && setupSh_r[13] |-> dropCnt_r == rounds;
  endproperty
  a_avg_run: assert property (p_avg_run)
    else $error("averaging run length off");
  property p_mask;
    convStart |-> setupSh_r[12 + convChannel];
  endproperty
  a_mask: assert property (p_mask)
    else $error("unselected channel started");
  property p_shutdown;
    setupSh_r[14:12] == 3'h0 && $stable(setupSh_r)
      |-> !convStart ##1 !convActive;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("activity in shutdown");
  property p_start_act;
    convStart |=> convActive && $stable(convChannel);
  endproperty
  a_start_act: assert property (p_start_act)
    else $error("start without conversion");
  property p_single;
    resultReady && !setupSh_r[15] && !regWr |=> !convStart [*8];
  endproperty
  a_single: assert property (p_single)
    else $error("single shot restarted");
  property p_rd_cal;
    regRd && regAddr == `ACS_OFS_CAL |=> regRdData == {1'b0, $past(calSh_r)};
  endproperty
  a_rd_cal: assert property (p_rd_cal)
    else $error("constant read wrong");
  property p_span;
    1'b1 |=> spanNarrow == $past(inputSpanSelect);
  endproperty
  a_span: assert property (p_span)
    else $error("span copy wrong");
endmodule : acs_check_monitor

// File: acs_front_model.sv
`include "acs_defs.svh"
module acs_front_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        convStart,
  input  wire logic        convActive,
  input  wire logic [1:0]  convChannel,
  input  wire logic        regWr,
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] nextVal,
  output logic      [15:0] dropSample,
  output logic signed [25:0] dropSum
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  idx;
  logic [15:0] smp;
  assign smp = nextVal ^ {idx, idx};
  // Outside a conversion the sample line churns, never holds
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dropSample <= 16'h0000;
      dropSum    <= 26'h0000000;
      idx        <= 8'h00;
    end else begin
      if (convStart) dropSample <= smp;
      else if (!convActive) dropSample <= ~dropSample;
      idx <= idx + 8'(convStart);
      if (regWr && regAddr == `ACS_OFS_SETUP) dropSum <= 26'h0000000;
      else if (convStart && convChannel == 2'h1)
        dropSum <= dropSum + $signed(smp);
    end
  end
endmodule : acs_front_model

// File: test_adc_config_and_shunt_result.sv
`include "acs_defs.svh"
module test_adc_config_and_shunt_result
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CT5 = 20;
  localparam int unsigned CT6 = 30;
  localparam int unsigned CT7 = 40;
  logic clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, span = 1'b0;
  logic [5:0]  regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000, nextVal = 16'h0000;
  logic [15:0] regRdData, dropSample, exp;
  logic [14:0] senseConstant;
  logic [1:0]  convChannel;
  logic        spanNarrow, convActive, convStart, resultReady;
  logic        chkCh = 1'b0, rdPend = 1'b0;
  logic signed [25:0] dropSum;
  logic [15:0] rdQ[$];
  logic [1:0]  chQ[$];
  int nErrors = 0, totalChecks = 0;
  int ctc[8] = '{500, 840, 1500, 2800, 5400, CT5, CT6, CT7};
  int rnd[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
  int shf[8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  logic [2:0] avgSel[3] = '{3'h1, 3'h2, 3'h7};
  acs_top #(.CT5_CYC(CT5), .CT6_CYC(CT6), .CT7_CYC(CT7)) dut (.clk(clk),
    .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .dropSample(dropSample), .inputSpanSelect(span),
    .spanNarrow(spanNarrow), .senseConstant(senseConstant),
    .convActive(convActive),
    .convChannel(convChannel), .convStart(convStart),
    .resultReady(resultReady));
  acs_front_model u_front (.clk(clk), .reset(reset), .convStart(convStart),
    .convActive(convActive), .convChannel(convChannel), .regWr(regWr),
    .regAddr(regAddr), .nextVal(nextVal), .dropSample(dropSample), .dropSum(dropSum));
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    totalChecks++;
    if (got !== want) begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    nextVal <= 16'($urandom);
    span <= 1'($urandom);
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    rdQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd
  // Either drain the start queue or catch one ready pulse
  task automatic waitOn(input int lim, input bit useQ);
    int i;
    for (i = 0; i < lim && (useQ ? chQ.size() != 0 : resultReady !== 1'b1); i++)
      @(negedge clk);
    if (i == lim) begin
      chk(16'hFFFF, 16'h0000);
      print_verdict();
    end
  endtask : waitOn
  always @(negedge clk) begin
    if (rdPend) chk(regRdData, rdQ.pop_front());
    rdPend = regRd;
    if (chkCh && convStart === 1'b1) begin
      if (chQ.size() == 0) chk(16'hFFFF, 16'h0000);
      else chk({14'h0, convChannel},
               {14'h0, chQ.pop_front()});
    end
  end
  initial begin
    void'($urandom(7808));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(`ACS_OFS_SETUP, `ACS_SETUP_RST);
    rd(`ACS_OFS_CAL, 16'h1000);
    rd(`ACS_OFS_DROP, `ACS_DROP_RST);
    chk({1'b0, senseConstant}, 16'h1000);
    wr(`ACS_OFS_SETUP, 16'h8B68);
    repeat (100) @(posedge clk);
    wr(`ACS_OFS_DROP, 16'hFFFF);
    rd(`ACS_OFS_DROP, 16'h0000);
    wr(`ACS_OFS_CAL, 16'hFFFF);
    rd(`ACS_OFS_CAL, 16'h7FFF);
    rd(6'h03, 16'h0000);
    chk({1'b0, senseConstant}, 16'h7FFF);
    $display("test registers done");
    chkCh = 1'b1;
    for (int m = 0; m < 16; m++) begin
      for (int c = 0; c < 3; c++) if (m[c]) chQ.push_back(2'(c));
      wr(`ACS_OFS_SETUP, {4'(m), 12'hB68});
      waitOn(400, 1'b1);
      if (m < 9) repeat (80) @(negedge clk);
    end
    chkCh = 1'b0;
    $display("test modes done");
    for (int c = 0; c < 8; c++) begin
      wr(`ACS_OFS_SETUP,
         {4'h7, 3'(c), 3'(c), 3'(c), 3'h0});
      waitOn(3 * ctc[c] + 40, 1'b0);
      exp = dropSum[15:0];
      repeat (10) @(negedge clk);
      rd(`ACS_OFS_DROP, exp);
    end
    $display("test times done");
    foreach (avgSel[i]) begin
      wr(`ACS_OFS_SETUP, {4'hA, 9'h16D, avgSel[i]});
      waitOn(30 * rnd[avgSel[i]] + 60, 1'b0);
      exp = 16'(dropSum >>> shf[avgSel[i]]);
      wr(`ACS_OFS_SETUP, 16'h8B68);
      rd(`ACS_OFS_DROP, exp);
    end
    $display("test averaging done");
    print_verdict();
  end
endmodule : test_adc_config_and_shunt_result
bind acs_top acs_check_monitor #(.CT5_CYC(CT5_CYC), .CT6_CYC(CT6_CYC),
  .CT7_CYC(CT7_CYC)) u_mon (.clk(clk), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .inputSpanSelect(inputSpanSelect), .spanNarrow(spanNarrow),
  .convActive(convActive), .convChannel(convChannel), .convStart(convStart),
  .resultReady(resultReady));
